// ===== design/fprc_top.sv
// Behaviour
// - ramp output one gradually when ramping active
// - rate code gives slot increments 1..48
// - ramp only while enable bit set
// - sync set ties speed inputs 2-4
// - sync clear ties speed inputs 3-4
// - output one floor follows bit 5
// - output two floor follows bit 6
// - output three floor follows bit 7
// - lock makes config register read-only
// - config at index 0x62, resets 0x00
`timescale 1ns/1ns
module fprc_top #(
  parameter int SLOT_CYCLES = fprc_pkg::SLOT_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [fprc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic auto_mode,
  input wire logic [7:0] duty_calc_one,
  input wire logic [7:0] duty_calc_two,
  input wire logic [7:0] duty_calc_three,
  input wire logic [2:0] below_floor,
  output logic [7:0] fan_drive_one,
  output logic [7:0] fan_drive_two,
  output logic [7:0] fan_drive_three,
  output logic [2:0] speed_sync_three
);
  import fprc_pkg::*;

  logic [7:0] cfg_reg;
  logic lock_reg;
  logic [7:0] min_reg [3];
  logic [31:0] slot_cnt_reg;
  logic slot_tick_reg;
  fprc_apb_state_t apb_state_reg;
  logic [7:0] target [3];
  logic [7:0] calc [3];
  logic [2:0] floor_mode;
  logic wr_done;
  logic rd_hit;
  logic [31:0] rd_data;

  fprc_ramp_if rif ();

  assign calc[0] = duty_calc_one;
  assign calc[1] = duty_calc_two;
  assign calc[2] = duty_calc_three;
  assign floor_mode = cfg_reg[FLOOR3_BIT:FLOOR1_BIT];

  function automatic logic is_reg(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
    is_reg = (a == fprc_addr(idx));
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = is_reg(a, CFG_IDX) || is_reg(a, LOCK_IDX) || is_reg(a, MIN_ONE_IDX) ||
             is_reg(a, MIN_TWO_IDX) || is_reg(a, MIN_THREE_IDX) || is_reg(a, STAT_IDX);
  endfunction

  // apb: setup, two wait cycles, then pready high for one edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      apb_state_reg <= FPRC_IDLE;
    end else begin
      unique case (apb_state_reg)
        FPRC_IDLE: begin
          if (psel && penable) begin
            apb_state_reg <= FPRC_ACCESS;
          end
        end
        FPRC_ACCESS: begin
          apb_state_reg <= FPRC_DONE;
        end
        FPRC_DONE: begin
          apb_state_reg <= FPRC_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= (apb_state_reg == FPRC_ACCESS);
      pslverr <= (apb_state_reg == FPRC_ACCESS) && !mapped(paddr);
    end
  end

  assign wr_done = psel && penable && pready && pwrite && pstrb[0] && mapped(paddr);

  always_comb begin
    rd_hit = 1'b1;
    rd_data = 32'h0;
    if (is_reg(paddr, CFG_IDX)) begin
      rd_data[7:0] = cfg_reg;
    end else if (is_reg(paddr, LOCK_IDX)) begin
      rd_data[LOCK_BIT] = lock_reg;
    end else if (is_reg(paddr, MIN_ONE_IDX)) begin
      rd_data[7:0] = min_reg[0];
    end else if (is_reg(paddr, MIN_TWO_IDX)) begin
      rd_data[7:0] = min_reg[1];
    end else if (is_reg(paddr, MIN_THREE_IDX)) begin
      rd_data[7:0] = min_reg[2];
    end else if (is_reg(paddr, STAT_IDX)) begin
      rd_data[7:0] = rif.current;
      rd_data[15:8] = target[0];
    end else begin
      rd_hit = 1'b0;
    end
  end

  // zero outside the ready cycle so stale reads never leak
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (apb_state_reg == FPRC_ACCESS && !pwrite && rd_hit) begin
      prdata <= rd_data;
    end else begin
      prdata <= 32'h0;
    end
  end

  // config register; lock blocks every later write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg <= CFG_RESET;
    end else if (wr_done && is_reg(paddr, CFG_IDX) && !lock_reg) begin
      cfg_reg <= pwdata[7:0];
    end
  end

  // lock can only be set; cleared by reset alone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_reg <= 1'b0;
    end else if (wr_done && is_reg(paddr, LOCK_IDX) && pwdata[LOCK_BIT]) begin
      lock_reg <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      min_reg[0] <= MIN_RESET;
      min_reg[1] <= MIN_RESET;
      min_reg[2] <= MIN_RESET;
    end else if (wr_done) begin
      if (is_reg(paddr, MIN_ONE_IDX)) begin
        min_reg[0] <= pwdata[7:0];
      end
      if (is_reg(paddr, MIN_TWO_IDX)) begin
        min_reg[1] <= pwdata[7:0];
      end
      if (is_reg(paddr, MIN_THREE_IDX)) begin
        min_reg[2] <= pwdata[7:0];
      end
    end
  end

  // time slot strobe for the ramp
  // free-running, so a new target may wait up to one slot
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slot_cnt_reg <= 32'h0;
      slot_tick_reg <= 1'b0;
    end else if (slot_cnt_reg >= 32'(SLOT_CYCLES - 1)) begin
      slot_cnt_reg <= 32'h0;
      slot_tick_reg <= 1'b1;
    end else begin
      slot_cnt_reg <= slot_cnt_reg + 32'h1;
      slot_tick_reg <= 1'b0;
    end
  end

  // below threshold less hysteresis: off or minimum duty
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_target
      always_comb begin
        if (auto_mode && below_floor[g]) begin
          target[g] = floor_mode[g] ? min_reg[g] : DUTY_OFF;
        end else begin
          target[g] = calc[g];
        end
      end
    end
  endgenerate

  assign rif.target = target[0];
  assign rif.step = fprc_step(cfg_reg[RATE_MSB:RATE_LSB]);
  assign rif.en = cfg_reg[RAMP_EN_BIT];
  assign rif.tick = slot_tick_reg;

  fprc_ramp u_ramp (
    .pclk(pclk),
    .presetn(presetn),
    .rif(rif)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fan_drive_one <= DUTY_OFF;
      fan_drive_two <= DUTY_OFF;
      fan_drive_three <= DUTY_OFF;
    end else begin
      fan_drive_one <= rif.current;
      fan_drive_two <= target[1];
      fan_drive_three <= target[2];
    end
  end

  // bit 0 is speed input two, bit 2 is speed input four
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      speed_sync_three <= SYNC_PART;
    end else begin
      speed_sync_three <= cfg_reg[SYNC_BIT] ? SYNC_ALL : SYNC_PART;
    end
  end

  a_bypass_follow: assert property (@(posedge pclk) disable iff (!presetn)
    !cfg_reg[RAMP_EN_BIT] |-> ##2 fan_drive_one == $past(target[0], 2))
    else $error("output one did not follow target with ramp off");
  a_ramp_gated: assert property (@(posedge pclk) disable iff (!presetn)
    cfg_reg[RAMP_EN_BIT] && !slot_tick_reg ##1 cfg_reg[RAMP_EN_BIT] && !slot_tick_reg
    |=> fan_drive_one == $past(fan_drive_one))
    else $error("output one changed between slots with ramp on");
  a_step_top: assert property (@(posedge pclk) disable iff (!presetn)
    cfg_reg[RATE_MSB:RATE_LSB] == 3'h7 |-> rif.step == 8'h30)
    else $error("fastest rate code not decoded to 48");
  a_floor_two: assert property (@(posedge pclk) disable iff (!presetn)
    auto_mode && below_floor[1]
    |=> fan_drive_two == ($past(cfg_reg[FLOOR2_BIT]) ? $past(min_reg[1]) : 8'h00))
    else $error("output two floor wrong");
  a_floor_three: assert property (@(posedge pclk) disable iff (!presetn)
    auto_mode && below_floor[2] && !cfg_reg[FLOOR3_BIT] |=> fan_drive_three == 8'h00)
    else $error("output three not off below threshold");
  a_floor_one: assert property (@(posedge pclk) disable iff (!presetn)
    auto_mode && below_floor[0] && cfg_reg[FLOOR1_BIT] |-> target[0] == min_reg[0])
    else $error("output one target not minimum duty");
  a_sync_all: assert property (@(posedge pclk) disable iff (!presetn)
    cfg_reg[SYNC_BIT] |=> speed_sync_three == 3'h7)
    else $error("speed inputs two to four not tied");
  a_sync_part: assert property (@(posedge pclk) disable iff (!presetn)
    !cfg_reg[SYNC_BIT] |=> speed_sync_three == 3'h6)
    else $error("speed input two tied while sync clear");
  a_lock_hold: assert property (@(posedge pclk) disable iff (!presetn)
    lock_reg |=> $stable(cfg_reg))
    else $error("config changed while locked");
  a_cfg_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_done && paddr == 12'h188 && !lock_reg |=> cfg_reg == $past(pwdata[7:0]))
    else $error("config write at index 0x62 lost");
  a_cfg_read: assert property (@(posedge pclk) disable iff (!presetn)
    pready && !pwrite && is_reg(paddr, CFG_IDX) |-> prdata[7:0] == cfg_reg)
    else $error("config read data differs from register");
  a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("ready held beyond one cycle");
  a_err_ready: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready)
    else $error("error flag without ready");
  a_rdata_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    !pready |-> prdata == 32'h0)
    else $error("read data outside ready cycle");
  a_lock_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    lock_reg |=> lock_reg)
    else $error("lock cleared without reset");
  a_min_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_done && is_reg(paddr, MIN_ONE_IDX) |=> min_reg[0] == $past(pwdata[7:0]))
    else $error("minimum duty one write lost");
  a_floor_one_off: assert property (@(posedge pclk) disable iff (!presetn)
    auto_mode && below_floor[0] && !cfg_reg[FLOOR1_BIT] |-> target[0] == DUTY_OFF)
    else $error("output one target not off");
  a_two_follow: assert property (@(posedge pclk) disable iff (!presetn)
    !(auto_mode && below_floor[1]) |=> fan_drive_two == $past(duty_calc_two))
    else $error("output two did not follow computed duty");
  a_three_follow: assert property (@(posedge pclk) disable iff (!presetn)
    !(auto_mode && below_floor[2]) |=> fan_drive_three == $past(duty_calc_three))
    else $error("output three did not follow computed duty");
  a_tick_single: assert property (@(posedge pclk) disable iff (!presetn)
    slot_tick_reg |=> !slot_tick_reg)
    else $error("slot strobe longer than one cycle");
  a_step_mid: assert property (@(posedge pclk) disable iff (!presetn)
    cfg_reg[RATE_MSB:RATE_LSB] == 3'h3 |-> rif.step == 8'h04)
    else $error("rate code three not decoded to 4");

  c_ramp_slot: cover property (@(posedge pclk) disable iff (!presetn)
    cfg_reg[RAMP_EN_BIT] && slot_tick_reg && target[0] != rif.current);
  c_locked_write: cover property (@(posedge pclk) disable iff (!presetn)
    lock_reg && wr_done && is_reg(paddr, CFG_IDX));
  c_floor_min: cover property (@(posedge pclk) disable iff (!presetn)
    auto_mode && below_floor[0] && cfg_reg[FLOOR1_BIT]);
  c_bad_addr: cover property (@(posedge pclk) disable iff (!presetn) pslverr);
  c_ramp_down: cover property (@(posedge pclk) disable iff (!presetn)
    cfg_reg[RAMP_EN_BIT] && slot_tick_reg && target[0] < rif.current);
endmodule

// ===== common/fprc_pkg.sv
package fprc_pkg;
  // register indexes; byte address is four times the index
  localparam logic [7:0] CFG_IDX = 8'h62;
  localparam logic [7:0] LOCK_IDX = 8'h40;
  localparam logic [7:0] MIN_ONE_IDX = 8'h64;
  localparam logic [7:0] MIN_TWO_IDX = 8'h65;
  localparam logic [7:0] MIN_THREE_IDX = 8'h66;
  localparam logic [7:0] STAT_IDX = 8'h70;
  localparam int ADDR_W = 12;

  // config register fields; LOCK_BIT is the lock register bit
  localparam int RATE_LSB = 0;
  localparam int RATE_MSB = 2;
  localparam int RAMP_EN_BIT = 3;
  localparam int SYNC_BIT = 4;
  localparam int FLOOR1_BIT = 5;
  localparam int FLOOR2_BIT = 6;
  localparam int FLOOR3_BIT = 7;
  localparam int LOCK_BIT = 0;

  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] MIN_RESET = 8'h80;
  localparam logic [7:0] DUTY_OFF = 8'h00;
  localparam logic [2:0] SYNC_ALL = 3'h7;
  localparam logic [2:0] SYNC_PART = 3'h6;

  // one time slot; 171 steps of 33%..100% take about 35 s
  localparam int SLOT_TIME_US = 205000;
  localparam int CLK_MHZ = 125;
  localparam int SLOT_CYCLES = SLOT_TIME_US * CLK_MHZ;

  typedef enum logic [1:0] {
    FPRC_IDLE,
    FPRC_ACCESS,
    FPRC_DONE
  } fprc_apb_state_t;

  function automatic logic [7:0] fprc_step(input logic [2:0] code);
    unique case (code)
      3'h0: fprc_step = 8'h01;
      3'h1: fprc_step = 8'h02;
      3'h2: fprc_step = 8'h03;
      3'h3: fprc_step = 8'h04;
      3'h4: fprc_step = 8'h08;
      3'h5: fprc_step = 8'h0c;
      3'h6: fprc_step = 8'h18;
      3'h7: fprc_step = 8'h30;
    endcase
  endfunction

  function automatic logic [ADDR_W-1:0] fprc_addr(input logic [7:0] idx);
    fprc_addr = {2'h0, idx, 2'h0};
  endfunction
endpackage

// ===== common/fprc_ramp_if.sv
`timescale 1ns/1ns
interface fprc_ramp_if;
  logic [7:0] target;
  logic [7:0] step;
  logic en;
  logic tick;
  logic [7:0] current;
  modport ctrl (output target, output step, output en, output tick, input current);
  modport ramp (input target, input step, input en, input tick, output current);
endinterface

// ===== design/fprc_ramp.sv
`timescale 1ns/1ns
module fprc_ramp (
  input wire logic pclk,
  input wire logic presetn,
  fprc_ramp_if.ramp rif
);
  import fprc_pkg::*;

  logic [7:0] current_reg;
  logic [8:0] up_sum;
  logic [8:0] dn_diff;

  assign up_sum = {1'b0, current_reg} + {1'b0, rif.step};
  assign dn_diff = {1'b0, current_reg} - {1'b0, rif.step};
  assign rif.current = current_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      current_reg <= DUTY_OFF;
    end else if (!rif.en) begin
      current_reg <= rif.target;
    end else if (rif.tick) begin
      // clamp so a big step never overshoots the target
      if (rif.target > current_reg) begin
        current_reg <= (up_sum >= {1'b0, rif.target}) ? rif.target : up_sum[7:0];
      end else if (rif.target < current_reg) begin
        current_reg <= (dn_diff[8] || dn_diff[7:0] <= rif.target) ? rif.target : dn_diff[7:0];
      end
    end
  end

  a_ramp_hold: assert property (@(posedge pclk) disable iff (!presetn)
    rif.en && !rif.tick |=> current_reg == $past(current_reg))
    else $error("ramp moved outside a time slot");
  a_ramp_no_jump: assert property (@(posedge pclk) disable iff (!presetn)
    rif.en && rif.tick && rif.target > current_reg + rif.step && current_reg < 8'h80
    |=> current_reg == $past(current_reg) + $past(rif.step))
    else $error("ramp step differs from decoded increment");
endmodule

// ===== test/fprc_fan_model.sv
`timescale 1ns/1ns
module fprc_fan_model (
  input wire logic pclk,
  input wire logic [7:0] fan_drive_one,
  input wire logic [7:0] fan_drive_two,
  input wire logic [7:0] fan_drive_three,
  input wire logic [2:0] speed_sync_three,
  output logic [2:0] spinning,
  output logic [2:0] tach_measured
);
  // a fan at 0x00 stops; its tach then gives no pulses
  always_ff @(posedge pclk) begin
    spinning <= {fan_drive_three != 8'h00, fan_drive_two != 8'h00, fan_drive_one != 8'h00};
  end
  // only inputs tied to output three follow that fan
  assign tach_measured = speed_sync_three & {3{spinning[2]}};
endmodule

// ===== test/test_fan_pwm_acoustic_ramp_config.sv
`timescale 1ns/1ns
module test_fan_pwm_acoustic_ramp_config;
  import fprc_pkg::*;
  localparam int SLOT = 16;
  localparam logic [7:0] STEPS [8] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h08, 8'h0c, 8'h18, 8'h30};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h1;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic auto_mode = 1'b0;
  logic [7:0] duty_one = 8'h00;
  logic [7:0] duty_two = 8'h55;
  logic [7:0] duty_three = 8'h55;
  logic [2:0] below = 3'h0;
  logic [7:0] drv_one;
  logic [7:0] drv_two;
  logic [7:0] drv_three;
  logic [2:0] sync3;
  logic [2:0] spinning;
  logic [2:0] tach;
  logic [31:0] rd;
  logic err;
  int failures = 0;
  int samples_checked = 0;

  always #4 pclk = ~pclk;

  fprc_top #(.SLOT_CYCLES(SLOT)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .auto_mode(auto_mode),
    .duty_calc_one(duty_one), .duty_calc_two(duty_two), .duty_calc_three(duty_three),
    .below_floor(below), .fan_drive_one(drv_one), .fan_drive_two(drv_two),
    .fan_drive_three(drv_three), .speed_sync_three(sync3));

  fprc_fan_model fan_u (.pclk(pclk), .fan_drive_one(drv_one), .fan_drive_two(drv_two),
    .fan_drive_three(drv_three), .speed_sync_three(sync3), .spinning(spinning),
    .tach_measured(tach));

  task automatic finish_test;
    if (failures == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // entered just after a rising edge; leaves one idle cycle behind
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 50) begin
      failures++;
      $display("ERROR %0t bus hang", $time);
      finish_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wait_change(output logic [7:0] v, output int cyc);
    logic [7:0] prev;
    prev = drv_one;
    for (cyc = 1; cyc < 200; cyc++) begin
      @(posedge pclk);
      if (drv_one !== prev) break;
    end
    if (cyc == 200) begin
      failures++;
      $display("ERROR %0t drive never moved", $time);
      finish_test();
    end
    v = drv_one;
  endtask

  task automatic t_reset;
    apb(1'b0, 12'h188, 32'h0);
    chk(rd, 32'h0, "cfg reset");
    chk({29'h0, sync3}, 32'h6, "sync reset");
  endtask

  task automatic t_floor;
    auto_mode <= 1'b1;
    below <= 3'h7;
    apb(1'b1, 12'h188, 32'h00);
    tick(4);
    chk({24'h0, drv_one}, 32'h0, "floor one off");
    chk({24'h0, drv_two}, 32'h0, "floor two off");
    chk({24'h0, drv_three}, 32'h0, "floor three off");
    chk({29'h0, spinning}, 32'h0, "fans stopped");
    apb(1'b1, 12'h188, 32'he0);
    tick(4);
    chk({24'h0, drv_one}, 32'h80, "floor one min");
    chk({24'h0, drv_two}, 32'h80, "floor two min");
    chk({24'h0, drv_three}, 32'h80, "floor three min");
    below <= 3'h0;
    tick(4);
    chk({24'h0, drv_three}, 32'h55, "above floor");
    auto_mode <= 1'b0;
  endtask

  task automatic t_sync;
    apb(1'b1, 12'h188, 32'h10);
    tick(2);
    chk({29'h0, sync3}, 32'h7, "sync all");
    chk({29'h0, tach}, 32'h7, "tach all");
    apb(1'b1, 12'h188, 32'h00);
    tick(2);
    chk({29'h0, sync3}, 32'h6, "sync part");
    chk({29'h0, tach}, 32'h6, "tach part");
  endtask

  task automatic t_regs;
    apb(1'b1, 12'h190, 32'h40);
    apb(1'b0, 12'h190, 32'h0);
    chk(rd, 32'h40, "min one readback");
    pstrb <= 4'h0;
    apb(1'b1, 12'h194, 32'h11);
    pstrb <= 4'h1;
    apb(1'b0, 12'h194, 32'h0);
    chk(rd, 32'h80, "strobe off ignored");
    auto_mode <= 1'b1;
    below <= 3'h1;
    apb(1'b1, 12'h188, 32'h20);
    tick(4);
    chk({24'h0, drv_one}, 32'h40, "floor one at min");
    apb(1'b0, 12'h1c0, 32'h0);
    chk(rd, 32'h4040, "status current and target");
    auto_mode <= 1'b0;
    below <= 3'h0;
    apb(1'b1, 12'h188, 32'h0);
  endtask

  task automatic t_immediate;
    duty_one <= 8'hc0;
    tick(3);
    chk({24'h0, drv_one}, 32'hc0, "no ramp");
    duty_one <= 8'h00;
    tick(3);
  endtask

  task automatic t_ramp;
    logic [7:0] v1;
    logic [7:0] v2;
    int c;
    for (int code = 0; code < 8; code++) begin
      duty_one <= 8'h00;
      apb(1'b1, 12'h188, 32'h0);
      apb(1'b1, 12'h188, 32'h8 | code);
      duty_one <= 8'hff;
      wait_change(v1, c);
      wait_change(v2, c);
      chk({24'h0, v1}, {24'h0, STEPS[code]}, "first step");
      chk({24'h0, v2 - v1}, {24'h0, STEPS[code]}, "step size");
      chk(c, SLOT, "slot spacing");
    end
    apb(1'b1, 12'h188, 32'h0);
  endtask

  task automatic t_lock;
    apb(1'b1, 12'h188, 32'h2a);
    apb(1'b1, 12'h100, 32'h1);
    apb(1'b1, 12'h188, 32'h55);
    chk({31'h0, err}, 32'h0, "locked write ok");
    apb(1'b0, 12'h188, 32'h0);
    chk(rd, 32'h2a, "locked value");
    apb(1'b0, 12'h3fc, 32'h0);
    chk({31'h0, err}, 32'h1, "unmapped err");
  endtask

  initial begin
    tick(12);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_floor();
    t_sync();
    t_regs();
    t_immediate();
    t_ramp();
    t_lock();
    finish_test();
  end
endmodule
